// ---- core/crlt_regs.vh ----
// constants for the card reader load and tag timing block
`ifndef CRLT_REGS_VH
`define CRLT_REGS_VH
// clock period in ns
`define CRLT_CLK_NS        100
// documented times in ns
`define CRLT_OSC_NS        140
`define CRLT_READY_PW_NS   1000
`define CRLT_PRESET_PW_NS  5000
`define CRLT_PH1_NS        500
`define CRLT_PH2_NS        1000
`define CRLT_RDYCLR_NS     500
// derived cycle counts (least times round up)
`define CRLT_OSC_CYC     ((`CRLT_OSC_NS + `CRLT_CLK_NS - 1) / `CRLT_CLK_NS)
`define CRLT_READY_CYC   ((`CRLT_READY_PW_NS + `CRLT_CLK_NS - 1) / `CRLT_CLK_NS)
`define CRLT_PRESET_CYC  ((`CRLT_PRESET_PW_NS + `CRLT_CLK_NS - 1) / `CRLT_CLK_NS)
`define CRLT_PH1_CYC     ((`CRLT_PH1_NS + `CRLT_CLK_NS - 1) / `CRLT_CLK_NS)
`define CRLT_PH2_CYC     ((`CRLT_PH2_NS + `CRLT_CLK_NS - 1) / `CRLT_CLK_NS)
`define CRLT_RDYCLR_CYC  ((`CRLT_RDYCLR_NS + `CRLT_CLK_NS - 1) / `CRLT_CLK_NS)
// counter presets
`define CRLT_PRESET_FEED  8'h63
`define CRLT_PRESET_XFER  8'h4E
// buffer geometry
`define CRLT_RANKS        100
`define CRLT_ROW_BITS     12
// shift and decrement pairs run after the card leaves
`define CRLT_CHAIN_PAIRS  5'h14
// timing chain patterns
`define CRLT_T_ZERO       5'h00
`define CRLT_T_FULL       5'h1F
`define CRLT_T4_MASK      5'h0F
// apb register byte addresses
`define CRLT_A_CTRL       12'h000
`define CRLT_A_STAT       12'h004
`define CRLT_A_COUNT      12'h008
`define CRLT_A_DATA       12'h00C
// control bits
`define CRLT_C_ACCEPT     0
`define CRLT_C_STACK      1
`define CRLT_C_SUPPRESS   2
`define CRLT_C_SENSECMD   3
`define CRLT_C_SENTDATA   4
`define CRLT_C_PROGRESS   5
`define CRLT_C_CLRLOAD    6
`endif

// ---- core/crlt_pulse.v ----
// retriggerable-free one-shot timed in system clock cycles
`timescale 1ns/1ps
module crlt_pulse #(
   parameter WIDTH = 10
) (
   // clock and reset
   input  wire core_clk,
   input  wire reset,
   // trigger and pulse
   input  wire trig,
   output reg  pulse,
   output wire fall
);
   reg [15:0] cnt_q;

   // count down while pulse stands, ignore triggers meanwhile
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 16'h0000;
         pulse <= 1'b0;
      end else if (!pulse && trig) begin
         cnt_q <= WIDTH[15:0] - 16'h0001;
         pulse <= 1'b1;
      end else if (pulse) begin
         if (cnt_q == 16'h0000)
            pulse <= 1'b0;
         else
            cnt_q <= cnt_q - 16'h0001;
      end
   end

   // trailing edge marker in the last cycle of the pulse
   assign fall = pulse && (cnt_q == 16'h0000);
endmodule // crlt_pulse

// ---- core/crlt_chain.v ----
// five stage tag line timing chain driven by a gated oscillator
`timescale 1ns/1ps
`include "crlt_regs.vh"
module crlt_chain #(
   parameter OSC_CYC = `CRLT_OSC_CYC
) (
   // clock and reset
   input  wire       core_clk,
   input  wire       reset,
   // control
   input  wire       start,
   input  wire       resp,
   // timing signals
   output reg  [4:0] tq,
   output wire       busy
);
   reg [7:0] osc_q;
   reg       run_q;
   wire      tick;
   wire      atT4;

   assign atT4 = (tq == `CRLT_T4_MASK);
   assign tick = run_q && (osc_q == 8'h00);
   assign busy = run_q || (tq != `CRLT_T_ZERO);

   // oscillator runs from start, halts at t4 until response, stops at zero
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         osc_q <= 8'h00;
         run_q <= 1'b0;
         tq    <= 5'h00;
      end else begin
         if (!run_q && tq == `CRLT_T_ZERO && start)
            run_q <= 1'b1;
         else if (!run_q && atT4 && resp)
            run_q <= 1'b1;
         if (run_q)
            osc_q <= (osc_q == 8'h00) ? OSC_CYC[7:0] - 8'h01
                                      : osc_q - 8'h01;
         if (tick) begin
            // set in order then clear in order
            if (tq != `CRLT_T_FULL && !tq[4])
               tq <= {tq[3:0], 1'b1};
            else
               tq <= {tq[3:0], 1'b0};
            // halt on the step that lands on t4, not on the step after
            if ({tq[3:0], 1'b1} == `CRLT_T4_MASK && !tq[4])
               run_q <= 1'b0;
            if (tq == 5'h10)
               run_q <= 1'b0;
         end
      end
   end
endmodule // crlt_chain

// ---- core/crlt_card_reader.v ----
// card reader adapter: card load control and tag line timing
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "crlt_regs.vh"
module crlt_card_reader #(
   parameter RANKS    = `CRLT_RANKS,
   parameter ROW_BITS = `CRLT_ROW_BITS
) (
   // clock and reset
   input  wire                core_clk,
   input  wire                reset,
   // apb slave
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [11:0]         paddr,
   input  wire [31:0]         pwdata,
   output reg  [31:0]         prdata,
   output wire                pready,
   output wire                pslverr,
   // card reader
   input  wire                readerReady,
   input  wire                readerBusy,
   input  wire                card_motion_fault,
   input  wire                readError,
   input  wire                rowStrobe,
   input  wire [ROW_BITS-1:0] rowData,
   output reg                 pickCommand,
   // selector channel tag lines
   input  wire                selectIn,
   input  wire                selection_hold,
   input  wire                pollAddress,
   output wire                selectOut,
   output reg                 serviceRequest,
   output reg                 statusTagIn,
   output reg  [4:0]          timing,
   // buffer output
   output reg  [ROW_BITS-1:0] columnOut,
   output reg                 dataReady_q
);
   // buffer ranks, index 0 is rank 1
   reg  [ROW_BITS-1:0] buf_q [0:RANKS-1];
   reg  [7:0]  count_q;
   reg         card_pick_flag_q;
   reg         loadDone_q;
   reg         load_done_edge_flag_q;
   reg         load_done_irq_flag_q;
   reg         readyIrq_q;
   reg         busyFlag_q;
   reg         blockFeed_q;
   reg         devFinished_q;
   reg         statusPending_q;
   reg         unitCheck_q;
   reg  [4:0]  sense_q;
   reg         selLatch_q;
   reg         ready_q;
   reg         rdyBusy_q;
   reg         strobe_q;
   reg         initialLoad_q;
   reg         chainEn_q;
   reg  [4:0]  chainLeft_q;
   reg  [7:0]  ctrl_q;
   reg  [3:0]  rdyClr_q;
   reg         polled_q;
   wire        readyPulse;
   wire        readyFall;
   wire        presetPulse;
   wire        ph1;
   wire        ph1Fall;
   wire        ph2;
   wire        ph2Fall;
   wire        shiftNow;
   wire        decNow;
   wire        underflow;
   wire        pickRise;
   wire        loadRise;
   wire        apbWr;
   wire        apbRd;
   wire [4:0]  tq;
   wire        chainBusy;
   wire        ending;
   wire        anySenseSet;
   wire [4:0]  senseSet;
   reg  [4:0]  sense_d;
   integer     i;

   // apb answers in the access cycle, no wait states
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign apbWr   = psel && penable && pwrite;
   assign apbRd   = psel && !penable && !pwrite;
   assign ending  = ctrl_q[`CRLT_C_SENTDATA];

   // reader ready one-shot, 1 us
   crlt_pulse #(.WIDTH(`CRLT_READY_CYC)) uReady (
      .core_clk (core_clk),
      .reset    (reset),
      .trig     (readerReady && !ready_q),
      .pulse    (readyPulse),
      .fall     (readyFall)
   );

   assign pickRise = readyFall && readerReady && !readerBusy
                     && !card_motion_fault;

   // preset one-shot, load value taken at its leading edge
   crlt_pulse #(.WIDTH(`CRLT_PRESET_CYC)) uPreset (
      .core_clk (core_clk),
      .reset    (reset),
      .trig     (pickRise || loadRise),
      .pulse    (presetPulse),
      .fall     ()
   );

   // two-phase internal chain, phase one then phase two
   crlt_pulse #(.WIDTH(`CRLT_PH1_CYC)) uPh1 (
      .core_clk (core_clk),
      .reset    (reset),
      .trig     (chainEn_q && !ph2 && !ph1 && !loadDone_q),
      .pulse    (ph1),
      .fall     (ph1Fall)
   );

   crlt_pulse #(.WIDTH(`CRLT_PH2_CYC)) uPh2 (
      .core_clk (core_clk),
      .reset    (reset),
      .trig     (ph1Fall),
      .pulse    (ph2),
      .fall     (ph2Fall)
   );

   // shift and decrement on the trailing edges
   assign shiftNow  = (strobe_q && !rowStrobe) || ph1Fall;
   assign decNow    = (strobe_q && !rowStrobe) || ph2Fall;
   assign underflow = decNow && (count_q == 8'h00);
   assign loadRise  = underflow && !loadDone_q;

   // tag line timing chain
   crlt_chain uChain (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (pollAddress && statusPending_q),
      .resp     (ctrl_q[`CRLT_C_ACCEPT] || ctrl_q[`CRLT_C_STACK]
                 || ctrl_q[`CRLT_C_SUPPRESS]),
      .tq       (tq),
      .busy     (chainBusy)
   );

   // column buffer, shifting toward the output rank
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (i = 0; i < RANKS; i = i + 1)
            buf_q[i] <= {ROW_BITS{1'b0}};
      end else if (shiftNow) begin
         buf_q[0] <= rowData;
         for (i = 1; i < RANKS; i = i + 1)
            buf_q[i] <= buf_q[i-1];
      end
   end

   // column down-counter with presets
   always @(posedge core_clk or posedge reset) begin
      if (reset)
         count_q <= 8'h00;
      else if (pickRise && !blockFeed_q)
         count_q <= `CRLT_PRESET_FEED;
      else if (loadRise)
         count_q <= `CRLT_PRESET_XFER;
      else if (decNow && count_q != 8'h00)
         count_q <= count_q - 8'h01;
   end

   // pick flag, load done and block feed
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         card_pick_flag_q <= 1'b0;
         loadDone_q       <= 1'b0;
         blockFeed_q      <= 1'b0;
         chainEn_q        <= 1'b0;
         rdyBusy_q        <= 1'b0;
         ready_q          <= 1'b0;
         strobe_q         <= 1'b0;
         dataReady_q      <= 1'b0;
         initialLoad_q    <= 1'b1;
         chainLeft_q      <= 5'h00;
      end else begin
         ready_q   <= readerReady;
         strobe_q  <= rowStrobe;
         rdyBusy_q <= readerBusy;
         if (card_motion_fault)
            card_pick_flag_q <= 1'b0;
         else if (readyFall)
            card_pick_flag_q <= pickRise;
         else if (readerBusy)
            card_pick_flag_q <= 1'b0;
         // underflow wins over a clear landing in the same cycle
         if (underflow)
            loadDone_q <= 1'b1;
         else if (readerReady && !ready_q)
            loadDone_q <= 1'b0;
         else if (ctrl_q[`CRLT_C_CLRLOAD])
            loadDone_q <= 1'b0;
         if (readerBusy && !rdyBusy_q)
            blockFeed_q <= 1'b1;
         else if (ctrl_q[`CRLT_C_SENTDATA])
            blockFeed_q <= 1'b0;
         // busy fall enables the internal chain for 20 pairs
         if (rdyBusy_q && !readerBusy) begin
            chainEn_q   <= 1'b1;
            chainLeft_q <= `CRLT_CHAIN_PAIRS;
         end else if (underflow || (ph2Fall && chainLeft_q == 5'h01)) begin
            chainEn_q   <= 1'b0;
            chainLeft_q <= 5'h00;
         end else if (ph2Fall && chainLeft_q != 5'h00)
            chainLeft_q <= chainLeft_q - 5'h01;
         if (ph2Fall && chainLeft_q == `CRLT_CHAIN_PAIRS)
            dataReady_q <= 1'b1;
         else if (pickRise)
            dataReady_q <= 1'b0;
         if (loadRise)
            initialLoad_q <= 1'b0;
      end
   end

   // feed request only while ready and the pick flag stand
   always @(posedge core_clk or posedge reset) begin
      if (reset)
         pickCommand <= 1'b0;
      else
         pickCommand <= card_pick_flag_q && readerReady;
   end

   // sense flags: intervention, equipment, motion, data, reject
   assign senseSet[0] = ending && readError;
   assign senseSet[1] = ending && readError;
   assign senseSet[2] = card_motion_fault && dataReady_q;
   assign senseSet[3] = 1'b0;
   assign senseSet[4] = 1'b0;
   assign anySenseSet = |senseSet;

   always @* begin
      sense_d = sense_q | senseSet;
   end

   // status and service request flags
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         load_done_edge_flag_q <= 1'b0;
         load_done_irq_flag_q  <= 1'b0;
         readyIrq_q            <= 1'b0;
         busyFlag_q            <= 1'b0;
         devFinished_q         <= 1'b0;
         statusPending_q       <= 1'b0;
         serviceRequest        <= 1'b0;
         unitCheck_q           <= 1'b0;
         sense_q               <= 5'h00;
         rdyClr_q              <= 4'h0;
         polled_q              <= 1'b0;
      end else begin
         sense_q <= sense_d;
         load_done_edge_flag_q <= loadRise;
         if (load_done_edge_flag_q || (rdyBusy_q && !readerReady
             && !blockFeed_q && !initialLoad_q))
            devFinished_q <= 1'b1;
         else if (ctrl_q[`CRLT_C_ACCEPT] || ctrl_q[`CRLT_C_SUPPRESS])
            devFinished_q <= 1'b0;
         // finished is a level dropping on the same pulse, so clear first
         if (ctrl_q[`CRLT_C_ACCEPT] || ctrl_q[`CRLT_C_SUPPRESS])
            statusPending_q <= 1'b0;
         else if (devFinished_q)
            statusPending_q <= 1'b1;
         serviceRequest <= statusPending_q;
         if ((anySenseSet && !ctrl_q[`CRLT_C_SENSECMD]) ||
             (ending && readError))
            unitCheck_q <= 1'b1;
         else if (ctrl_q[`CRLT_C_ACCEPT])
            unitCheck_q <= 1'b0;
         if (loadRise && initialLoad_q) begin
            load_done_irq_flag_q <= 1'b1;
            readyIrq_q           <= 1'b1;
         end else if (rdyClr_q == `CRLT_RDYCLR_CYC) begin
            readyIrq_q <= 1'b0;
         end
         if (readyIrq_q)
            busyFlag_q <= 1'b1;
         rdyClr_q <= (busyFlag_q && readyIrq_q) ? rdyClr_q + 4'h1 : 4'h0;
         polled_q <= chainBusy;
      end
   end

   // selection latch and loop propagation
   always @(posedge core_clk or posedge reset) begin
      if (reset)
         selLatch_q <= 1'b0;
      else if (!selection_hold)
         selLatch_q <= 1'b0;
      else if (selectIn)
         selLatch_q <= 1'b1;
   end

   // latch keeps the loop passing while hold stands, request blocks it
   assign selectOut = (selectIn || selLatch_q) && !serviceRequest;

   // outbound status tag follows the timing chain, t1 to t4
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         statusTagIn <= 1'b0;
         timing      <= 5'h00;
         columnOut   <= {ROW_BITS{1'b0}};
      end else begin
         timing      <= tq;
         statusTagIn <= tq[0] && !tq[4];
         columnOut   <= buf_q[RANKS-1];
      end
   end

   // software control, pulses clear themselves; stack keeps request
   always @(posedge core_clk or posedge reset) begin
      if (reset)
         ctrl_q <= 8'h00;
      else if (apbWr && paddr == `CRLT_A_CTRL)
         ctrl_q <= pwdata[7:0];
      else
         ctrl_q <= ctrl_q & 8'h38;
   end

   // read mux registered at setup, valid in the access cycle
   always @(posedge core_clk or posedge reset) begin
      if (reset)
         prdata <= 32'h00000000;
      else if (apbRd) begin
         case (paddr)
            `CRLT_A_CTRL:  prdata <= {24'h000000, ctrl_q};
            `CRLT_A_STAT:  prdata <= {13'h0000, sense_q, polled_q,
                                      busyFlag_q, readyIrq_q,
                                      load_done_irq_flag_q, unitCheck_q,
                                      statusPending_q, devFinished_q,
                                      blockFeed_q, dataReady_q,
                                      loadDone_q, card_pick_flag_q,
                                      selLatch_q, serviceRequest, 1'b0};
            `CRLT_A_COUNT: prdata <= {24'h000000, count_q};
            `CRLT_A_DATA:  prdata <= {{(32-ROW_BITS){1'b0}},
                                      buf_q[RANKS-1]};
            default:       prdata <= 32'h00000000;
         endcase
      end
   end
endmodule // crlt_card_reader

// ---- testbench/crlt_card_reader_chk.sv ----
// port assertions for the card reader adapter
`timescale 1ns/1ps
module crlt_card_reader_chk (
   // clock and reset
   input wire       core_clk,
   input wire       reset,
   // watched ports
   input wire       psel,
   input wire       penable,
   input wire       pwrite,
   input wire       readerReady,
   input wire       card_motion_fault,
   input wire       pickCommand,
   input wire       selectOut,
   input wire       serviceRequest,
   input wire [4:0] timing
);
   logic [3:0] idleWr_q;
   // cycles since the last apb write, saturating so it never wraps
   always @(posedge core_clk or posedge reset) begin
      if (reset) idleWr_q <= 4'h0;
      else if (psel && penable && pwrite) idleWr_q <= 4'h0;
      else if (idleWr_q != 4'hF) idleWr_q <= idleWr_q + 4'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   chk_pick_needs_ready: assert property (
      pickCommand |-> $past(readerReady))
      else $error("pick raised without ready");
   chk_fault_drops_pick: assert property (
      card_motion_fault |-> ##[1:3] !pickCommand)
      else $error("pick kept during motion fault");
   chk_timing_shape: assert property (
      timing inside {5'h00, 5'h01, 5'h03, 5'h07, 5'h0F,
                     5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10})
      else $error("timing stages out of order");
   chk_step_spacing: assert property (
      $changed(timing) |=> $stable(timing))
      else $error("timing stepped faster than oscillator");
   chk_chain_advance: assert property (
      timing == 5'h01 |-> ##[1:12] timing == 5'h0F)
      else $error("chain did not reach fourth stage");
   chk_chain_halt: assert property (
      timing == 5'h0F && idleWr_q > 4'h4 |=> timing == 5'h0F)
      else $error("chain left fourth stage without response");
   chk_chain_return: assert property (
      timing == 5'h10 |-> ##[1:4] timing == 5'h00)
      else $error("chain did not return to idle");
   chk_request_blocks: assert property (
      serviceRequest |-> !selectOut)
      else $error("selection passed during service request");
endmodule // crlt_card_reader_chk

bind crlt_card_reader crlt_card_reader_chk i_crlt_card_reader_chk (
   .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .readerReady(readerReady),
   .card_motion_fault(card_motion_fault), .pickCommand(pickCommand),
   .selectOut(selectOut), .serviceRequest(serviceRequest), .timing(timing));

// ---- testbench/crlt_reader_model.sv ----
// behavioural card reader feeding one card of 80 rows
`timescale 1ns/1ps
module crlt_reader_model (
   // clock
   input wire         core_clk,
   // bench control
   input wire         goReady,
   input wire         letGo,
   output logic       rowsDone,
   // reader lines
   input wire         pickCommand,
   output logic       readerReady,
   output logic       readerBusy,
   output logic       rowStrobe,
   output logic [11:0] rowData
);
   int row;
   // ready simply follows the bench's hopper and start state
   assign readerReady = goReady;
   // one card per run; busy held until the bench lets the card leave
   initial begin
      readerBusy = 1'b0;
      rowStrobe = 1'b0;
      rowData = 12'h000;
      rowsDone = 1'b0;
      forever begin
         @(posedge core_clk);
         if (pickCommand === 1'b1 && !rowsDone) begin
            repeat (60) @(posedge core_clk);
            readerBusy <= 1'b1;
            for (row = 0; row < 80; row++) begin
               repeat (3) @(posedge core_clk);
               rowData <= 12'hA00 + row[11:0];
               rowStrobe <= 1'b1;
               repeat (3) @(posedge core_clk);
               rowStrobe <= 1'b0;
               repeat (2) @(posedge core_clk);
               rowData <= ~rowData; // stale data must not be trusted
            end
            rowsDone <= 1'b1;
            while (!letGo) @(posedge core_clk);
            readerBusy <= 1'b0;
         end
      end
   end
endmodule // crlt_reader_model

// ---- testbench/crlt_card_reader_test.sv ----
// self-checking bench for the card reader adapter
`timescale 1ns/1ps
module crlt_card_reader_test;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, pickCommand, selectOut, serviceRequest;
   logic        statusTagIn, dataReady_q, readerReady, readerBusy;
   logic        rowStrobe, rowsDone;
   logic        goReady = 1'b0, letGo = 1'b0, fault = 1'b0;
   logic        readErr = 1'b0;
   logic        selectIn = 1'b0, selHold = 1'b0, pollAddress = 1'b0;
   logic [11:0] rowData, columnOut;
   logic [4:0]  timing;
   int          failCount = 0, totalChecks = 0, cycles = 0;

   crlt_card_reader i_crlt_card_reader (.core_clk(core_clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .readerReady(readerReady), .readerBusy(readerBusy),
      .card_motion_fault(fault), .readError(readErr), .rowStrobe(rowStrobe),
      .rowData(rowData), .pickCommand(pickCommand), .selectIn(selectIn),
      .selection_hold(selHold), .pollAddress(pollAddress),
      .selectOut(selectOut), .serviceRequest(serviceRequest),
      .statusTagIn(statusTagIn), .timing(timing), .columnOut(columnOut),
      .dataReady_q(dataReady_q));
   crlt_reader_model i_crlt_reader_model (.core_clk(core_clk),
      .goReady(goReady), .letGo(letGo), .rowsDone(rowsDone),
      .pickCommand(pickCommand), .readerReady(readerReady),
      .readerBusy(readerBusy), .rowStrobe(rowStrobe), .rowData(rowData));

   // clock and a ceiling well above the expected run of about 1200 cycles
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         summarize();
      end
   end

   task summarize();
      if (failCount == 0 && totalChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer, held until pready is seen at a rising edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task sFaultBlocksPick();
      fault <= 1'b1;
      goReady <= 1'b1;
      repeat (30) @(posedge core_clk);
      chk("pick under fault", 0, pickCommand);
      goReady <= 1'b0;
      fault <= 1'b0;
      repeat (5) @(posedge core_clk);
   endtask

   task sInitialLoad();
      goReady <= 1'b1;
      while (pickCommand !== 1'b1) @(posedge core_clk);
      repeat (40) @(posedge core_clk);
      apb(1'b0, 12'h008, 0);
      chk("feed preset", 99, rd);
      while (!rowsDone) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
      apb(1'b0, 12'h008, 0);
      chk("count after rows", 19, rd);
      letGo <= 1'b1;
      while (serviceRequest !== 1'b1) @(posedge core_clk);
      repeat (20) @(posedge core_clk);
      apb(1'b0, 12'h008, 0);
      chk("transfer preset", 78, rd);
      chk("column 1 out", 12'hA00, columnOut);
      chk("data ready", 1, dataReady_q);
      apb(1'b0, 12'h004, 0);
      chk("status flags", 32'h15F2, rd & 32'h3FF2);
      chk("block feed", 1, rd[6]);
      selectIn <= 1'b1;
      selHold <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("select blocked", 0, selectOut);
   endtask

   // poll once and answer the halted chain with a control pulse
   task pollOnce(input logic [31:0] ctrl);
      pollAddress <= 1'b1;
      while (timing !== 5'h0F) @(posedge core_clk);
      pollAddress <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk("chain halted", 5'h0F, timing);
      chk("status tag up", 1, statusTagIn);
      apb(1'b1, 12'h000, ctrl);
      while (timing !== 5'h00) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      chk("status tag down", 0, statusTagIn);
   endtask

   task sPollStack();
      pollOnce(32'h2);
      chk("request kept", 1, serviceRequest);
      chk("select still blocked", 0, selectOut);
   endtask

   task sPollAccept();
      pollOnce(32'h1);
      chk("request dropped", 0, serviceRequest);
      chk("select passes", 1, selectOut);
   endtask

   // read error is ignored until the ending, then flags unit check
   task sReadError();
      readErr <= 1'b1;
      apb(1'b0, 12'h004, 0);
      chk("error before ending", 0, rd & 32'h0007C200);
      apb(1'b1, 12'h000, 32'h10);
      apb(1'b0, 12'h004, 0);
      chk("error at ending", 32'hC200, rd & 32'h0007C200);
      readErr <= 1'b0;
   endtask

   task sUnmapped();
      apb(1'b1, 12'h010, 32'hFFFF);
      apb(1'b0, 12'h010, 0);
      chk("unmapped read", 0, rd);
      chk("slave error", 0, pslverr);
   endtask

   initial begin
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk("idle timing", 0, timing);
      chk("idle request", 0, serviceRequest);
      sUnmapped();
      sFaultBlocksPick();
      sInitialLoad();
      sPollStack();
      sPollAccept();
      sReadError();
      summarize();
   end
endmodule // crlt_card_reader_test
